// ---- dcc_map.svh ----
/*
 Register map and timing constants for the converter control block.
 Assumes an AXI4-Lite slave with 32-bit data and a 20 MHz clock.
*/
// What this block does
// - While enabled, each data write launches a conversion of the written value.
// - While disabled, a data write only stores the value.
// - Setting enable from 0 to 1 converts the stored value.
// - Enable bit written 1 switches the converter on, 0 switches it off.
// - Pin buffer enable bit gates driving the output to the pin.
// - Output goes to comparator and sampling converter once enabled, not halted and past start-up.
// - Internal delivery works with pin buffer enable at 0.
// - Run-in-standby 1 with clock running keeps converting in standby.
// - Run-in-standby 0 halts conversion in standby.
// - Halted in standby powers off converter and output buffer.
// - Leaving standby re-enables both, waits a start-up delay before converting.
// - Power-down always switches converter and buffer off.
// - Debug halt does not affect the block.
// - Conversion code is 8 bits, ground to reference.
// - Peripheral clock only; no interrupts and no events.
// - Control: run-in-standby bit 7, pin buffer bit 6, enable bit 0.
// - Control resets to all zeros.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

`define DCC_IDX_CONTROL   8'h00
`define DCC_IDX_VALUE     8'h01
`define DCC_ADDR_CONTROL  (8'(`DCC_IDX_CONTROL * 4))
`define DCC_ADDR_VALUE    (8'(`DCC_IDX_VALUE * 4))
`define DCC_ADDR_STATUS   8'h08

`define DCC_BIT_RUNSTBY   7
`define DCC_BIT_PINBUF    6
`define DCC_BIT_ENABLE    0
`define DCC_CTRL_MASK     8'hC1
`define DCC_CTRL_RESET    8'h00
`define DCC_VALUE_RESET   8'h00

`define DCC_BIT_ST_ACTIVE 0
`define DCC_BIT_ST_PWR    1
`define DCC_BIT_ST_WARM   2

`define DCC_RESP_OKAY     2'h0
`define DCC_RESP_SLVERR   2'h2

// Start-up time after standby exit, in ns, and its cycle count (rounded up)
`define DCC_STARTUP_NS    1000
`define DCC_CLK_NS        50
`define DCC_STARTUP_CYC   ((`DCC_STARTUP_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)

`endif

// ---- dcc_pkg.sv ----
/*
 Types shared by the converter control block.
 Assumes dcc_map.svh for numeric constants.
*/
package dcc_pkg;
  typedef logic [7:0] dcc_code_t;
  typedef enum logic [1:0] {
    DCC_OFF    = 2'b00,
    DCC_WARM   = 2'b01,
    DCC_ACTIVE = 2'b10
  } dcc_state_t;
endpackage

// ---- dcc_control.sv ----
/*
 Converter control: AXI4-Lite register slave, conversion launch and sleep handling.
 Assumes sleep and standby inputs synchronous to aclk; analog string lives outside.
*/
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_control (
  input  wire logic              aclk,             // Peripheral clock
  input  wire logic              aresetn,          // Sync reset, active low
  input  wire logic [7:0]        s_axi_awaddr,     // Write address
  input  wire logic              s_axi_awvalid,    // Write address valid
  output logic                   s_axi_awready,    // Write address ready
  input  wire logic [31:0]       s_axi_wdata,      // Write data
  input  wire logic [3:0]        s_axi_wstrb,      // Write strobes
  input  wire logic              s_axi_wvalid,     // Write data valid
  output logic                   s_axi_wready,     // Write data ready
  output logic [1:0]             s_axi_bresp,      // Write response
  output logic                   s_axi_bvalid,     // Write response valid
  input  wire logic              s_axi_bready,     // Write response ready
  input  wire logic [7:0]        s_axi_araddr,     // Read address
  input  wire logic              s_axi_arvalid,    // Read address valid
  output logic                   s_axi_arready,    // Read address ready
  output logic [31:0]            s_axi_rdata,      // Read data
  output logic [1:0]             s_axi_rresp,      // Read response
  output logic                   s_axi_rvalid,     // Read data valid
  input  wire logic              s_axi_rready,     // Read data ready
  input  wire logic              standby_sleep,    // System in standby sleep
  input  wire logic              powerdown_sleep,  // System in power-down sleep
  input  wire logic              per_clk_running,  // Peripheral clock kept in standby
  output dcc_pkg::dcc_code_t     conv_code,        // Code applied to resistor string
  output logic                   conv_launch,      // One-cycle conversion start
  output logic                   conv_power,       // Converter powered
  output logic                   pin_buffer_on,    // Pin output buffer powered
  output logic                   internal_out_on   // Output offered to comparator/ADC
);
  import dcc_pkg::*;

  // Register state
  logic [7:0] converter_control;
  dcc_code_t  conversion_value;
  logic [7:0] next_converter_control;
  dcc_code_t  next_conversion_value;

  // Bus state
  logic       aw_held, w_held, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_lane0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic       next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0] next_aw_addr, next_w_data;
  logic       next_w_lane0;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // Conversion state
  dcc_state_t state, next_state;
  logic [7:0] warm_cnt, next_warm_cnt;
  logic       pending, next_pending;
  dcc_code_t  code_q, next_code;
  logic       launch_q, next_launch;

  logic       wr_fire, wr_ctrl, wr_value, wr_ok;
  logic       enable_bit, halted;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  assign s_axi_awready = !aw_held && !bvalid_q;
  assign s_axi_wready  = !w_held && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  assign enable_bit = converter_control[`DCC_BIT_ENABLE];
  // Standby without run-in-standby, or standby with the clock gone, or power-down
  assign halted = powerdown_sleep
    || (standby_sleep && !(converter_control[`DCC_BIT_RUNSTBY] && per_clk_running));

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr_q;
    next_w_data  = w_data_q;
    next_w_lane0 = w_lane0_q;
    next_bvalid  = bvalid_q;
    next_bresp   = bresp_q;
    next_rvalid  = rvalid_q;
    next_rresp   = rresp_q;
    next_rdata   = rdata_q;
    wr_fire  = 1'b0;
    wr_ctrl  = 1'b0;
    wr_value = 1'b0;
    wr_ok    = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (aw_held && w_held) begin
      wr_fire = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      if (addr_is(aw_addr_q, `DCC_ADDR_CONTROL)) begin
        wr_ok   = 1'b1;
        wr_ctrl = w_lane0_q;
      end else if (addr_is(aw_addr_q, `DCC_ADDR_VALUE)) begin
        wr_ok    = 1'b1;
        wr_value = w_lane0_q;
      end else if (addr_is(aw_addr_q, `DCC_ADDR_STATUS)) begin
        wr_ok = 1'b1;
      end
      next_bresp = wr_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `DCC_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (addr_is(s_axi_araddr, `DCC_ADDR_CONTROL)) begin
        next_rdata[7:0] = converter_control;
      end else if (addr_is(s_axi_araddr, `DCC_ADDR_VALUE)) begin
        next_rdata[7:0] = conversion_value;
      end else if (addr_is(s_axi_araddr, `DCC_ADDR_STATUS)) begin
        next_rdata[`DCC_BIT_ST_ACTIVE] = (state == DCC_ACTIVE);
        next_rdata[`DCC_BIT_ST_PWR]    = conv_power;
        next_rdata[`DCC_BIT_ST_WARM]   = (state == DCC_WARM);
      end else begin
        next_rresp = `DCC_RESP_SLVERR;
      end
    end
  end

  // Unused control bits are not stored and read as zero
  always_comb begin
    next_converter_control = converter_control;
    next_conversion_value  = conversion_value;
    if (wr_fire && wr_ctrl) begin
      next_converter_control = w_data_q & `DCC_CTRL_MASK;
    end
    if (wr_fire && wr_value) begin
      next_conversion_value = w_data_q;
    end
  end

  // A launch request waits in pending until the converter is powered and warm
  always_comb begin
    next_state    = state;
    next_warm_cnt = warm_cnt;
    next_pending  = pending;
    next_code     = code_q;
    next_launch   = 1'b0;
    if (wr_fire && wr_value && enable_bit) begin
      next_pending = 1'b1;
    end
    if (wr_fire && wr_ctrl && !enable_bit && w_data_q[`DCC_BIT_ENABLE]) begin
      next_pending = 1'b1;
    end
    case (state)
      DCC_OFF: begin
        if (enable_bit && !halted) begin
          next_state    = DCC_WARM;
          next_warm_cnt = 8'h00;
        end
      end
      DCC_WARM: begin
        if (!enable_bit || halted) begin
          next_state = DCC_OFF;
        end else if (warm_cnt == 8'(`DCC_STARTUP_CYC - 1)) begin
          next_state = DCC_ACTIVE;
        end else begin
          next_warm_cnt = warm_cnt + 8'h01;
        end
      end
      DCC_ACTIVE: begin
        if (!enable_bit || halted) begin
          next_state = DCC_OFF;
        end else if (pending) begin
          next_code    = conversion_value;
          next_launch  = 1'b1;
          next_pending = (wr_fire && wr_value);
        end
      end
      default: begin
        next_state = DCC_OFF;
      end
    endcase
    if (wr_fire && wr_ctrl && !w_data_q[`DCC_BIT_ENABLE]) begin
      next_pending = 1'b0;
    end
  end

  // No debug-halt input: the block runs on regardless of the processor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_control <= `DCC_CTRL_RESET;
      conversion_value  <= `DCC_VALUE_RESET;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
      state     <= DCC_OFF;
      warm_cnt  <= 8'h00;
      pending   <= 1'b0;
      code_q    <= `DCC_VALUE_RESET;
      launch_q  <= 1'b0;
    end else begin
      converter_control <= next_converter_control;
      conversion_value  <= next_conversion_value;
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      aw_addr_q <= next_aw_addr;
      w_data_q  <= next_w_data;
      w_lane0_q <= next_w_lane0;
      bvalid_q  <= next_bvalid;
      bresp_q   <= next_bresp;
      rvalid_q  <= next_rvalid;
      rresp_q   <= next_rresp;
      rdata_q   <= next_rdata;
      state     <= next_state;
      warm_cnt  <= next_warm_cnt;
      pending   <= next_pending;
      code_q    <= next_code;
      launch_q  <= next_launch;
    end
  end

  assign conv_code       = code_q;
  assign conv_launch     = launch_q;
  assign conv_power      = (state != DCC_OFF);
  assign internal_out_on = (state == DCC_ACTIVE);
  assign pin_buffer_on   = conv_power && converter_control[`DCC_BIT_PINBUF];

endmodule

// ---- dcc_control_asserts.sv ----
/*
 Port checker for the converter control block.
 Assumes it is bound to dcc_control and sees one clock domain.
*/
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_control_asserts (
  input wire logic               aclk,            // Clock
  input wire logic               aresetn,         // Sync reset, active low
  input wire logic               standby_sleep,   // Standby request
  input wire logic               powerdown_sleep, // Power-down request
  input wire logic               per_clk_running, // Clock kept in standby
  input wire dcc_pkg::dcc_code_t conv_code,       // Applied code
  input wire logic               conv_launch,     // Launch pulse
  input wire logic               conv_power,      // Converter powered
  input wire logic               pin_buffer_on,   // Pin buffer powered
  input wire logic               internal_out_on  // Internal output offered
);
  import dcc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Warm-up lasts 20 cycles; eight is what the unrolled form can afford
  sequence s_warming;
    !internal_out_on [*8];
  endsequence
  logic [7:0] pwr_cycles;
  // Counts powered cycles so the whole warm-up is checked beyond the repeat limit
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv_power) begin
      pwr_cycles <= 8'h00;
    end else if (pwr_cycles != 8'hFF) begin
      pwr_cycles <= pwr_cycles + 8'h01;
    end
  end
  chk_warm_count: assert property (internal_out_on |-> pwr_cycles >= 8'(`DCC_STARTUP_CYC))
    else $error("output offered before full start-up");
  chk_code_hold: assert property (!conv_launch |-> $stable(conv_code))
    else $error("code changed without a launch");
  chk_pin_gate: assert property (pin_buffer_on |-> conv_power)
    else $error("pin buffer on while converter off");
  chk_internal_pwr: assert property (internal_out_on |-> conv_power)
    else $error("internal output without power");
  chk_pd_off: assert property (powerdown_sleep |=> !conv_power)
    else $error("powered during power-down");
  chk_stby_off: assert property (standby_sleep && !per_clk_running |=> !conv_power)
    else $error("powered in standby without clock");
  chk_launch_active: assert property (conv_launch |-> $past(internal_out_on))
    else $error("launch while not active");
  chk_warm_delay: assert property ($rose(conv_power) |-> s_warming)
    else $error("output offered before start-up");
  chk_launch_pulse: assert property (conv_launch |=> !conv_launch)
    else $error("launch longer than one cycle");
endmodule
bind dcc_control dcc_control_asserts chk (.aclk, .aresetn, .standby_sleep, .powerdown_sleep,
  .per_clk_running, .conv_code, .conv_launch, .conv_power, .pin_buffer_on, .internal_out_on);

// ---- test_dac_conversion_control.sv ----
/*
 Self-checking bench for the converter control block.
 Assumes dcc_control with its AXI4-Lite slave and a 20 MHz clock.
*/
`timescale 1ns/1ps
`include "dcc_map.svh"
module test_dac_conversion_control;
  import dcc_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, standby_sleep, powerdown_sleep;
  logic        per_clk_running, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, conv_launch, conv_power;
  logic        pin_buffer_on, internal_out_on;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  dcc_code_t   conv_code;
  int          bad_count, n_checks, n_launch;

  dcc_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_sleep, .powerdown_sleep,
    .per_clk_running, .conv_code, .conv_launch, .conv_power, .pin_buffer_on,
    .internal_out_on);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Launch is a one-cycle pulse, so one mid-cycle sample sees it once
  always @(negedge aclk) if (conv_launch === 1'b1) n_launch++;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ends mid-cycle so that outputs are read settled, never at their launching edge
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Ready values seen mid-cycle are the ones sampled at the next edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ar, done;
    int n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!done && n < 50) begin
      n++;
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      ar = s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (done) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    if (!done) begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic wait_launch(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (conv_launch !== 1'b1 && n < 40);
    chk(conv_launch, 1'b1);
    chk(conv_code, exp);
  endtask

  task automatic t_reset();
    bus(0, `DCC_ADDR_CONTROL, 0);
    chk(rd, 32'h0000_0000);
    chk(conv_power, 1'b0);
    bus(0, 8'h0C, 0);
    chk(rsp, `DCC_RESP_SLVERR);
    bus(1, 8'h0C, 32'h11);
    chk(rsp, `DCC_RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    bus(1, `DCC_ADDR_VALUE, 32'hAA);
    s_axi_wstrb <= 4'hF;
    chk(rsp, `DCC_RESP_OKAY);
    bus(0, `DCC_ADDR_VALUE, 0);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_disabled();
    bus(1, `DCC_ADDR_VALUE, 32'h5A);
    chk(rsp, `DCC_RESP_OKAY);
    cyc(5);
    chk(n_launch, 0);
    chk(conv_code, 8'h00);
    bus(0, `DCC_ADDR_VALUE, 0);
    chk(rd, 32'h5A);
    bus(1, `DCC_ADDR_CONTROL, 32'h01);
    wait_launch(8'h5A);
    cyc(1);
    chk(internal_out_on, 1'b1);
    chk(pin_buffer_on, 1'b0);
    bus(0, `DCC_ADDR_STATUS, 0);
    chk(rd, 32'h0000_0003);
    $display("test enable done");
  endtask

  task automatic t_enabled();
    bus(1, `DCC_ADDR_VALUE, 32'hFF);
    wait_launch(8'hFF);
    bus(1, `DCC_ADDR_VALUE, 32'h00);
    wait_launch(8'h00);
    bus(1, `DCC_ADDR_CONTROL, 32'hFF);
    bus(0, `DCC_ADDR_CONTROL, 0);
    chk(rd, 32'hC1);
    chk(pin_buffer_on, 1'b1);
    $display("test enabled writes done");
  endtask

  task automatic t_standby();
    int k;
    @(posedge aclk);
    standby_sleep <= 1'b1;
    bus(1, `DCC_ADDR_VALUE, 32'h33);
    wait_launch(8'h33);
    @(posedge aclk);
    per_clk_running <= 1'b0;
    cyc(2);
    chk(conv_power, 1'b0);
    chk(pin_buffer_on, 1'b0);
    bus(1, `DCC_ADDR_CONTROL, 32'h41);
    per_clk_running <= 1'b1;
    k = n_launch;
    bus(1, `DCC_ADDR_VALUE, 32'h77);
    cyc(3);
    chk(n_launch, k);
    chk(conv_power, 1'b0);
    @(posedge aclk);
    standby_sleep <= 1'b0;
    cyc(2);
    chk(internal_out_on, 1'b0);
    chk(pin_buffer_on, 1'b1);
    wait_launch(8'h77);
    $display("test standby done");
  endtask

  task automatic t_powerdown();
    bus(1, `DCC_ADDR_CONTROL, 32'hC1);
    powerdown_sleep <= 1'b1;
    cyc(2);
    chk(conv_power, 1'b0);
    chk(pin_buffer_on, 1'b0);
    @(posedge aclk);
    powerdown_sleep <= 1'b0;
    bus(1, `DCC_ADDR_CONTROL, 32'h00);
    cyc(2);
    chk(conv_power, 1'b0);
    $display("test power-down done");
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, standby_sleep, powerdown_sleep, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    per_clk_running = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_disabled();
    t_enabled();
    t_standby();
    t_powerdown();
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end
endmodule
